// File: inc/timing_pkg.sv
// Opcode timing tables, encodings and helpers for the instruction sequencer
package timing_pkg;

  // ****************************************
  // Encodings
  // ****************************************
  localparam int CORE_FMAX_MHZ = 25;
  localparam logic [7:0] OP_MULTIPLY_ACC_BY_B = 8'hA4;
  localparam logic [7:0] OP_DIVIDE_ACC_BY_B = 8'h84;
  localparam logic [7:0] OP_CMP_IMM_JUMP = 8'hB4;
  localparam logic [7:0] OP_MOVX_RD_DATA_POINTER = 8'hE0;
  localparam logic [7:0] OP_MOVX_WR_DATA_POINTER = 8'hF0;
  localparam logic [15:0] RESET_PC = 16'h0000;

  // ****************************************
  // Timing tables: {bytes, cycles not taken, cycles taken}, upper nibble F down to 0
  // ****************************************
  localparam logic [191:0] COL0 = {12'h133, 12'h133, 12'h222, 12'h222, 12'h222, 12'h222,
    12'h333, 12'h233, 12'h223, 12'h223, 12'h223, 12'h223, 12'h334, 12'h334, 12'h334, 12'h111};
  localparam logic [191:0] COL1 = {16{12'h233}};
  localparam logic [191:0] COL2 = {12'h133, 12'h133, 12'h222, 12'h222, 12'h222, 12'h222,
    12'h222, 12'h222, 12'h222, 12'h222, 12'h222, 12'h222, 12'h155, 12'h155, 12'h344, 12'h344};
  localparam logic [191:0] COL3 = {12'h133, 12'h133, 12'h111, 12'h111, 12'h111, 12'h111,
    12'h133, 12'h133, 12'h133, 12'h333, 12'h333, 12'h333, 12'h111, 12'h111, 12'h111, 12'h111};
  localparam logic [191:0] COL4 = {12'h111, 12'h111, 12'h111, 12'h111, 12'h334, 12'h144,
    12'h222, 12'h188, 12'h222, 12'h222, 12'h222, 12'h222, 12'h222, 12'h222, 12'h111, 12'h111};
  localparam logic [191:0] COL5 = {12'h222, 12'h222, 12'h334, 12'h222, 12'h345, 12'h111,
    12'h222, 12'h333, 12'h333, 12'h222, 12'h222, 12'h222, 12'h222, 12'h222, 12'h222, 12'h222};
  localparam logic [191:0] COL6 = {12'h122, 12'h122, 12'h122, 12'h122, 12'h345, 12'h222,
    12'h122, 12'h222, 12'h222, 12'h122, 12'h122, 12'h122, 12'h122, 12'h122, 12'h122, 12'h122};
  localparam logic [191:0] COLR = {12'h111, 12'h111, 12'h223, 12'h111, 12'h334, 12'h222,
    12'h111, 12'h222, 12'h222, 12'h111, 12'h111, 12'h111, 12'h111, 12'h111, 12'h111, 12'h111};

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [11:0] timing_entry(input logic [7:0] op);
    int idx;
    idx = 12 * int'(op[7:4]);
    case (op[3:0])
      4'h0: timing_entry = COL0[idx +: 12];
      4'h1: timing_entry = COL1[idx +: 12];
      4'h2: timing_entry = COL2[idx +: 12];
      4'h3: timing_entry = COL3[idx +: 12];
      4'h4: timing_entry = COL4[idx +: 12];
      4'h5: timing_entry = COL5[idx +: 12];
      4'h6, 4'h7: timing_entry = COL6[idx +: 12];
      default: timing_entry = COLR[idx +: 12];
    endcase
  endfunction : timing_entry

  function automatic logic is_arith(input logic [7:0] op);
    is_arith = (op[7:4] == 4'h2) || (op[7:4] == 4'h3) || (op[7:4] == 4'h9);
  endfunction : is_arith

  function automatic logic is_logic(input logic [7:0] op);
    is_logic = (op[7:4] == 4'h4) || (op[7:4] == 4'h5) || (op[7:4] == 4'h6);
  endfunction : is_logic

endpackage : timing_pkg

// File: rtl/core_timing_seq.sv
// Instruction fetch and cycle sequencer of the pipelined 8-bit core
`timescale 1ns/100ps
module core_timing_seq
  import timing_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Program memory
  input wire logic [7:0] code_byte_in,
  output logic [ADDR_W-1:0] code_addr_out,
  // Datapath
  input wire logic branch_cond_in,
  input wire logic [ADDR_W-1:0] jump_target_in,
  // Interrupt entry
  input wire logic irq_req_in,
  input wire logic [ADDR_W-1:0] irq_vector_in,
  // Debugger
  input wire logic dbg_halt_req_in,
  input wire logic dbg_run_req_in,
  input wire logic dbg_step_req_in,
  input wire logic bp_enable_in,
  input wire logic [ADDR_W-1:0] bp_addr_in,
  input wire logic dbg_access_req_in,
  // Instruction status
  output logic [7:0] opcode_out,
  output logic [7:0] operand1_out,
  output logic [7:0] operand2_out,
  output logic [3:0] cycle_index_out,
  output logic retire_out,
  output logic branch_taken_out,
  output logic [3:0] instr_bytes_out,
  output logic [3:0] instr_cycles_out,
  output logic irq_ack_out,
  // Debug status
  output logic halted_out,
  output logic bp_hit_out,
  output logic dbg_grant_out
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {ST_DECODE, ST_EXEC, ST_HALT} seq_state_type;

  seq_state_type state_r;
  logic [7:0] op_r;
  logic [3:0] cyc_r;
  logic [3:0] fetched_r;

  logic [7:0] cur_op;
  logic [3:0] len;
  logic [3:0] cyc_nt;
  logic [3:0] cyc_tk;
  logic cond;
  logic flow;
  logic boundary;
  logic hold;
  logic irq_take;
  logic start;
  logic active;
  logic [3:0] cyc_now;
  logic [3:0] fetched_now;
  logic nt_exit;
  logic last;
  logic finish;
  logic taken;
  logic fetch;

  // ****************************************
  // Decode
  // ****************************************
  assign boundary = (state_r == ST_DECODE);
  assign cur_op = boundary ? code_byte_in : op_r;

  opcode_timing u_timing (
    .opcode_in(cur_op),
    .bytes_out(len),
    .cyc_nt_out(cyc_nt),
    .cyc_tk_out(cyc_tk),
    .cond_out(cond),
    .flow_out(flow)
  );

  debug_ctrl #(
    .ADDR_W(ADDR_W)
  ) u_debug (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .boundary_in(boundary),
    .pc_in(code_addr_out),
    .halt_req_in(dbg_halt_req_in),
    .run_req_in(dbg_run_req_in),
    .step_req_in(dbg_step_req_in),
    .bp_enable_in(bp_enable_in),
    .bp_addr_in(bp_addr_in),
    .access_req_in(dbg_access_req_in),
    .hold_out(hold),
    .halted_out(halted_out),
    .bp_hit_out(bp_hit_out),
    .grant_out(dbg_grant_out)
  );

  // ****************************************
  // Cycle accounting
  // ****************************************
  assign irq_take = boundary && !hold && irq_req_in;
  assign start = boundary && !hold && !irq_req_in;
  assign active = start || (state_r == ST_EXEC);
  assign cyc_now = boundary ? 4'h1 : cyc_r;
  assign fetched_now = boundary ? 4'h0 : fetched_r;
  assign nt_exit = cond && (cyc_now == cyc_nt) && !branch_cond_in;
  assign last = nt_exit || (cyc_now == cyc_tk);
  assign finish = active && last;
  assign taken = finish && flow && !nt_exit;
  assign fetch = active && (fetched_now < len);

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      state_r <= ST_DECODE;
    end else begin
      case (state_r)
        ST_DECODE: begin
          if (hold)
            state_r <= ST_HALT;
          else if (start && !last)
            state_r <= ST_EXEC;
        end
        ST_EXEC: begin
          if (last)
            state_r <= ST_DECODE;
        end
        ST_HALT: begin
          if (!hold)
            state_r <= ST_DECODE;
        end
        default: state_r <= ST_DECODE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      cyc_r <= 4'h0;
      fetched_r <= 4'h0;
      op_r <= 8'h00;
    end else if (start) begin
      cyc_r <= 4'h2;
      fetched_r <= 4'h1;
      op_r <= code_byte_in;
    end else if (state_r == ST_EXEC) begin
      if (!last)
        cyc_r <= cyc_r + 4'h1;
      if (fetch)
        fetched_r <= fetched_r + 4'h1;
    end
  end

  // ****************************************
  // Program counter and operand fetch
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in)
      code_addr_out <= ADDR_W'(RESET_PC);
    else if (irq_take)
      code_addr_out <= irq_vector_in;
    else if (taken)
      code_addr_out <= jump_target_in;
    else if (fetch)
      code_addr_out <= code_addr_out + ADDR_W'(1);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      operand1_out <= 8'h00;
      operand2_out <= 8'h00;
    end else if ((state_r == ST_EXEC) && fetch) begin
      if (fetched_r == 4'h1)
        operand1_out <= code_byte_in;
      else
        operand2_out <= code_byte_in;
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      retire_out <= 1'b0;
      branch_taken_out <= 1'b0;
      irq_ack_out <= 1'b0;
      cycle_index_out <= 4'h0;
    end else begin
      retire_out <= finish;
      branch_taken_out <= taken;
      irq_ack_out <= irq_take;
      cycle_index_out <= active ? cyc_now : 4'h0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      opcode_out <= 8'h00;
      instr_bytes_out <= 4'h0;
      instr_cycles_out <= 4'h0;
    end else if (finish) begin
      opcode_out <= cur_op;
      instr_bytes_out <= fetched_now + (fetch ? 4'h1 : 4'h0);
      instr_cycles_out <= cyc_now;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [11:0] ret_ent;
  logic [11:0] dec_ent;

  assign ret_ent = timing_entry(opcode_out);
  assign dec_ent = timing_entry(code_byte_in);

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_max8;
    retire_out |-> (instr_cycles_out >= 4'h1) && (instr_cycles_out <= 4'h8);
  endproperty
  a_max8: assert property (p_max8) else $error("instruction over eight cycles");

  property p_div;
    retire_out && (opcode_out == OP_DIVIDE_ACC_BY_B) |->
      (instr_cycles_out == 4'h8) && (instr_bytes_out == 4'h1);
  endproperty
  a_div: assert property (p_div) else $error("divide timing wrong");

  property p_mul;
    retire_out && (opcode_out == OP_MULTIPLY_ACC_BY_B) |->
      (instr_cycles_out == 4'h4) && (instr_bytes_out == 4'h1);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply timing wrong");

  property p_one_per_clock;
    boundary && !hold && !irq_req_in && (dec_ent[7:0] == 8'h11) |=>
      retire_out && (instr_cycles_out == 4'h1) && (state_r == ST_DECODE);
  endproperty
  a_one_per_clock: assert property (p_one_per_clock) else $error("no single cycle retire");

  property p_bytes;
    retire_out |-> (instr_bytes_out == ret_ent[11:8]) && (instr_bytes_out <= instr_cycles_out);
  endproperty
  a_bytes: assert property (p_bytes) else $error("byte count wrong");

  property p_cond;
    retire_out && (ret_ent[7:4] != ret_ent[3:0]) |->
      (instr_cycles_out == (branch_taken_out ? ret_ent[3:0] : ret_ent[7:4])) &&
      (ret_ent[3:0] == ret_ent[7:4] + 4'h1);
  endproperty
  a_cond: assert property (p_cond) else $error("branch cycles wrong");

  property p_reg;
    retire_out && is_arith(opcode_out) && opcode_out[3] |->
      (instr_bytes_out == 4'h1) && (instr_cycles_out == 4'h1);
  endproperty
  a_reg: assert property (p_reg) else $error("register arithmetic timing");

  property p_dir;
    retire_out && is_arith(opcode_out) && (opcode_out[3:0] == 4'h5) |->
      (instr_bytes_out == 4'h2) && (instr_cycles_out == 4'h2);
  endproperty
  a_dir: assert property (p_dir) else $error("direct arithmetic timing");

  property p_ind;
    retire_out && is_arith(opcode_out) && (opcode_out[3:1] == 3'h3) |->
      (instr_bytes_out == 4'h1) && (instr_cycles_out == 4'h2);
  endproperty
  a_ind: assert property (p_ind) else $error("indirect arithmetic timing");

  property p_imm;
    retire_out && is_arith(opcode_out) && (opcode_out[3:0] == 4'h4) |->
      (instr_bytes_out == 4'h2) && (instr_cycles_out == 4'h2);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate arithmetic timing");

  property p_logic;
    retire_out && is_logic(opcode_out) && (opcode_out[3:0] >= 4'h4) |->
      (instr_bytes_out == (opcode_out[3:1] == 3'h2 ? 4'h2 : 4'h1)) &&
      (instr_cycles_out == (opcode_out[3] ? 4'h1 : 4'h2));
  endproperty
  a_logic: assert property (p_logic) else $error("logical op timing");

  property p_dir_acc;
    retire_out && is_logic(opcode_out) && (opcode_out[3:0] == 4'h2) |->
      (instr_bytes_out == 4'h2) && (instr_cycles_out == 4'h2);
  endproperty
  a_dir_acc: assert property (p_dir_acc) else $error("logical to direct timing");

  property p_dir_imm;
    retire_out && is_logic(opcode_out) && (opcode_out[3:0] == 4'h3) |->
      (instr_bytes_out == 4'h3) && (instr_cycles_out == 4'h3);
  endproperty
  a_dir_imm: assert property (p_dir_imm) else $error("immediate to direct timing");

  property p_cjne;
    retire_out && (opcode_out == OP_CMP_IMM_JUMP) |->
      (instr_cycles_out == (branch_taken_out ? 4'h4 : 4'h3));
  endproperty
  a_cjne: assert property (p_cjne) else $error("compare and jump timing");

  property p_movx;
    retire_out && ((opcode_out == OP_MOVX_RD_DATA_POINTER) ||
      (opcode_out == OP_MOVX_WR_DATA_POINTER)) |->
      (instr_bytes_out == 4'h1) && (instr_cycles_out == 4'h3);
  endproperty
  a_movx: assert property (p_movx) else $error("external move timing");

  property p_wait;
    retire_out && (instr_cycles_out > 4'h1) |->
      ($past(state_r) == ST_EXEC) && ($past(cycle_index_out) == instr_cycles_out - 4'h1);
  endproperty
  a_wait: assert property (p_wait) else $error("instruction ended early");

  property p_halt;
    halted_out && $past(halted_out) |-> $stable(code_addr_out) && !retire_out;
  endproperty
  a_halt: assert property (p_halt) else $error("core moved while halted");

  property p_grant;
    dbg_grant_out |-> $past(halted_out);
  endproperty
  a_grant: assert property (p_grant) else $error("debug access while running");

  c_divide: cover property (retire_out && (opcode_out == OP_DIVIDE_ACC_BY_B));
  c_taken: cover property (retire_out && branch_taken_out && (ret_ent[7:4] != ret_ent[3:0]));
  c_step: cover property (halted_out ##1 !halted_out ##[1:10] halted_out);
  c_irq: cover property (irq_ack_out);

endmodule : core_timing_seq

// File: rtl/debug_ctrl.sv
// Debug halt, step, breakpoint and access grant control
`timescale 1ns/100ps
module debug_ctrl #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Core view
  input wire logic boundary_in,
  input wire logic [ADDR_W-1:0] pc_in,
  // Debugger requests
  input wire logic halt_req_in,
  input wire logic run_req_in,
  input wire logic step_req_in,
  input wire logic bp_enable_in,
  input wire logic [ADDR_W-1:0] bp_addr_in,
  input wire logic access_req_in,
  // Status
  output logic hold_out,
  output logic halted_out,
  output logic bp_hit_out,
  output logic grant_out
);

  logic resume_r;
  logic step_r;
  logic bp_match;
  logic stop;
  logic release_now;

  assign bp_match = bp_enable_in && (pc_in == bp_addr_in);
  assign stop = boundary_in && !resume_r && (halt_req_in || bp_match || step_r);
  assign release_now = halted_out && (run_req_in || step_req_in);
  assign hold_out = halted_out || stop;

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      halted_out <= 1'b0;
      resume_r <= 1'b0;
      step_r <= 1'b0;
      bp_hit_out <= 1'b0;
      grant_out <= 1'b0;
    end else begin
      if (stop)
        halted_out <= 1'b1;
      else if (release_now)
        halted_out <= 1'b0;
      if (release_now)
        resume_r <= 1'b1;
      else if (boundary_in)
        resume_r <= 1'b0;
      if (halted_out && step_req_in)
        step_r <= 1'b1;
      else if (stop)
        step_r <= 1'b0;
      bp_hit_out <= stop && bp_match;
      grant_out <= halted_out && access_req_in;
    end
  end

endmodule : debug_ctrl

// File: rtl/opcode_timing.sv
// Opcode decoder giving length, cycle counts and flow class
`timescale 1ns/100ps
module opcode_timing
  import timing_pkg::*;
(
  // Opcode
  input wire logic [7:0] opcode_in,
  // Timing
  output logic [3:0] bytes_out,
  output logic [3:0] cyc_nt_out,
  output logic [3:0] cyc_tk_out,
  output logic cond_out,
  output logic flow_out
);

  logic [11:0] ent;

  always_comb begin
    ent = timing_entry(opcode_in);
    bytes_out = ent[11:8];
    cyc_nt_out = ent[7:4];
    cyc_tk_out = ent[3:0];
    cond_out = (ent[7:4] != ent[3:0]);
    flow_out = cond_out || (opcode_in[3:0] == 4'h1) || (opcode_in == 8'h02) ||
               (opcode_in == 8'h12) || (opcode_in == 8'h22) || (opcode_in == 8'h32) ||
               (opcode_in == 8'h73) || (opcode_in == 8'h80);
  end

endmodule : opcode_timing

// File: testbench/code_mem_model.sv
// Program memory model answering in the same cycle
`timescale 1ns/100ps
module code_mem_model (
  // Fetch
  input wire logic [15:0] addr_in,
  output logic [7:0] data_out,
  // Load
  input wire logic load_stb_in,
  input wire logic [15:0] load_addr_in,
  input wire logic [7:0] load_data_in
);
  logic [7:0] mem_r [0:4095];

  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem_r[i] = 8'h00;
    end
  end

  always @(posedge load_stb_in) begin
    mem_r[load_addr_in[11:0]] <= load_data_in;
  end

  assign data_out = mem_r[addr_in[11:0]];
endmodule : code_mem_model

// File: testbench/pipelined_8bit_core_timing_tb_top.sv
// Self-checking bench of the instruction sequencer
`timescale 1ns/100ps
module pipelined_8bit_core_timing_tb_top;
  typedef struct {int op; int b; int cyc; int tk; int op1; int op2; int cond; int tgt;} exp_type;
  localparam int NT = 26;
  // ****************************************
  // Timing table of the bench model
  // ****************************************
  int tab_op[NT] = '{8'h28, 8'h38, 8'h98, 8'h25, 8'h96, 8'h34, 8'h58, 8'h45, 8'h66, 8'h54,
    8'h52, 8'h62, 8'h53, 8'h43, 8'hA4, 8'h84, 8'hB4, 8'hE0, 8'hF0, 8'h40, 8'hA5, 8'h00,
    8'h80, 8'h02, 8'h22, 8'hB5};
  int tab_b[NT] = '{1, 1, 1, 2, 1, 2, 1, 2, 1, 2, 2, 2, 3, 3, 1, 1, 3, 1, 1, 2, 1, 1,
    2, 3, 1, 3};
  int tab_nt[NT] = '{1, 1, 1, 2, 2, 2, 1, 2, 2, 2, 2, 2, 3, 3, 4, 8, 3, 3, 3, 2, 1, 1,
    3, 4, 5, 4};
  int tab_tk[NT] = '{1, 1, 1, 2, 2, 2, 1, 2, 2, 2, 2, 2, 3, 3, 4, 8, 4, 3, 3, 3, 1, 1,
    3, 4, 5, 5};
  // Unconditional flow change
  int tab_fl[NT] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0,
    1, 1, 1, 0};
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] code_byte;
  logic [15:0] code_addr_out;
  logic branch_cond_in = 1'b0;
  logic [15:0] jump_target_in = 16'h0000;
  logic dbg_halt_req_in = 1'b0;
  logic dbg_run_req_in = 1'b0;
  logic dbg_step_req_in = 1'b0;
  logic bp_enable_in = 1'b0;
  logic [15:0] bp_addr_in = 16'h0000;
  logic dbg_access_req_in = 1'b0;
  logic irq_req_in = 1'b0;
  logic [15:0] irq_vector_in = 16'h0000;
  logic [7:0] opcode_out, operand1_out, operand2_out;
  logic [3:0] cycle_index_out, instr_bytes_out, instr_cycles_out;
  logic retire_out, branch_taken_out, halted_out, bp_hit_out, dbg_grant_out, irq_ack_out;
  logic ld_stb = 1'b0;
  logic [15:0] ld_addr = 16'h0000;
  logic [7:0] ld_data = 8'h00;
  exp_type exp_q[$];
  exp_type nop_e = '{0, 1, 1, 0, 0, 0, 0, 0};
  int unsigned seed_r = 90;
  int miscompares = 0;
  int check_count = 0;
  int since = 0;
  int retires = 0;
  bit mon_on = 0;
  bit gap_ok = 0;
  bit bp_seen = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  core_timing_seq #(.ADDR_W(16)) u_core_timing_seq (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .code_byte_in(code_byte), .code_addr_out(code_addr_out),
    .branch_cond_in(branch_cond_in), .jump_target_in(jump_target_in),
    .irq_req_in(irq_req_in), .irq_vector_in(irq_vector_in),
    .dbg_halt_req_in(dbg_halt_req_in), .dbg_run_req_in(dbg_run_req_in),
    .dbg_step_req_in(dbg_step_req_in), .bp_enable_in(bp_enable_in), .bp_addr_in(bp_addr_in),
    .dbg_access_req_in(dbg_access_req_in), .opcode_out(opcode_out),
    .operand1_out(operand1_out), .operand2_out(operand2_out),
    .cycle_index_out(cycle_index_out), .retire_out(retire_out),
    .branch_taken_out(branch_taken_out), .instr_bytes_out(instr_bytes_out),
    .instr_cycles_out(instr_cycles_out), .irq_ack_out(irq_ack_out), .halted_out(halted_out),
    .bp_hit_out(bp_hit_out), .dbg_grant_out(dbg_grant_out)
  );

  code_mem_model u_code_mem_model (
    .addr_in(code_addr_out), .data_out(code_byte),
    .load_stb_in(ld_stb), .load_addr_in(ld_addr), .load_data_in(ld_data)
  );

  function automatic int unsigned xorshift_next();
    seed_r ^= seed_r << 13;
    seed_r ^= seed_r >> 17;
    seed_r ^= seed_r << 5;
    return seed_r;
  endfunction : xorshift_next

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic load(input int a, input int d);
    ld_addr = 16'(a);
    ld_data = 8'(d);
    #0.1 ld_stb = 1'b1;
    #0.1 ld_stb = 1'b0;
  endtask : load

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ****************************************
  // Retire monitor and branch condition driver
  // ****************************************
  always @(negedge ref_clk_in) begin
    exp_type e;
    if (mon_on) begin
      if (halted_out === 1'b1 || irq_ack_out === 1'b1) gap_ok = 0;
      if (bp_hit_out === 1'b1) bp_seen = 1;
      since++;
      if (retire_out === 1'b1) begin
        e = exp_q.size() > 0 ? exp_q.pop_front() : nop_e;
        check("opcode", e.op, opcode_out);
        check("bytes", e.b, instr_bytes_out);
        check("cycles", e.cyc, instr_cycles_out);
        check("cycle index", e.cyc, cycle_index_out);
        check("taken", e.tk, branch_taken_out);
        if (e.b > 1) check("operand1", e.op1, operand1_out);
        if (e.b > 2) check("operand2", e.op2, operand2_out);
        if (gap_ok) check("retire gap", e.cyc, since);
        gap_ok = 1;
        since = 0;
        retires++;
      end
    end
    e = exp_q.size() > 0 ? exp_q[0] : nop_e;
    branch_cond_in = e.cond[0];
    jump_target_in = 16'(e.tgt);
  end

  initial begin
    #50000;
    miscompares++;
    $display("watchdog expired");
    print_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    exp_type e;
    int pc, k, n, a0, r0;
    pc = 0;
    for (int i = 0; i < 3 * NT; i++) begin
      k = (i < 2 * NT) ? i % NT : int'(xorshift_next() % NT);
      e.op = tab_op[k];
      e.b = tab_b[k];
      e.cond = (i < NT) ? 0 : (i < 2 * NT) ? 1 : int'(xorshift_next() & 1);
      e.op1 = int'(xorshift_next() & 255);
      e.op2 = int'(xorshift_next() & 255);
      e.tk = ((tab_nt[k] != tab_tk[k]) && e.cond) || tab_fl[k];
      e.cyc = e.tk ? tab_tk[k] : tab_nt[k];
      load(pc, e.op);
      if (e.b > 1) load(pc + 1, e.op1);
      if (e.b > 2) load(pc + 2, e.op2);
      pc += e.b;
      e.tgt = pc;
      exp_q.push_back(e);
    end
    repeat (12) @(negedge ref_clk_in);
    check("reset pc", 16'h0000, code_addr_out);
    check("reset retire", 0, retire_out);
    check("reset halted", 0, halted_out);
    reset_n_in = 1'b1;
    mon_on = 1;
    for (n = 0; n < 2000 && exp_q.size() > 0; n++) @(negedge ref_clk_in);
    check("program drained", 0, exp_q.size());
    $display("test program timing done");
    dbg_access_req_in = 1'b1;
    @(negedge ref_clk_in);
    check("grant running", 0, dbg_grant_out);
    dbg_halt_req_in = 1'b1;
    for (n = 0; n < 20 && halted_out !== 1'b1; n++) @(negedge ref_clk_in);
    dbg_halt_req_in = 1'b0;
    a0 = code_addr_out;
    repeat (3) @(negedge ref_clk_in);
    check("halted", 1, halted_out);
    check("grant halted", 1, dbg_grant_out);
    check("pc frozen", 16'(a0), code_addr_out);
    check("idle index", 0, cycle_index_out);
    dbg_access_req_in = 1'b0;
    r0 = retires;
    dbg_step_req_in = 1'b1;
    @(negedge ref_clk_in);
    dbg_step_req_in = 1'b0;
    for (n = 0; n < 20 && halted_out !== 1'b1; n++) @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    check("step retires", 1, 16'(retires - r0));
    check("step pc", 16'(a0 + 1), code_addr_out);
    $display("test halt and step done");
    bp_addr_in = code_addr_out + 16'h0004;
    bp_enable_in = 1'b1;
    dbg_run_req_in = 1'b1;
    @(negedge ref_clk_in);
    dbg_run_req_in = 1'b0;
    for (n = 0; n < 30 && halted_out !== 1'b1; n++) @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    check("bp pc", bp_addr_in, code_addr_out);
    check("bp flag", 1, bp_seen);
    dbg_run_req_in = 1'b1;
    @(negedge ref_clk_in);
    dbg_run_req_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    check("resume past bp", 0, halted_out);
    bp_enable_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    $display("test breakpoint done");
    irq_vector_in = 16'h0800;
    irq_req_in = 1'b1;
    @(negedge ref_clk_in);
    irq_req_in = 1'b0;
    check("irq ack", 1, irq_ack_out);
    check("irq pc", 16'h0800, code_addr_out);
    @(negedge ref_clk_in);
    check("irq ack pulse", 0, irq_ack_out);
    repeat (2) @(negedge ref_clk_in);
    $display("test interrupt entry done");
    print_verdict();
  end
endmodule : pipelined_8bit_core_timing_tb_top
